// file: hdl/asd_area.v
// external area decoder for a 29-bit bus address
`timescale 1ns/10ps
`include "asd_regs.vh"
module asd_area (
  // bus address
  input wire [28:0] ext_addr,
  // decode
  output wire [2:0] area,
  output wire card,
  output wire area7,
  output wire ctl_img
);
  assign area = ext_addr[28:26];
  assign card = (area == `ASD_AREA_CARD_LO) | (area == `ASD_AREA_CARD_HI);
  assign area7 = (area == 3'h7);
  assign ctl_img = (ext_addr[28:26] == `ASD_CIMG_TOP);
endmodule

// file: hdl/asd_region.v
// region and on-chip window classifier
`timescale 1ns/10ps
`include "asd_regs.vh"
module asd_region (
  // address in
  input wire [31:0] addr,
  // classification
  output reg [2:0] region,
  output wire stq_hit,
  output wire arr_hit,
  output wire [2:0] arr_sel,
  output wire ctl_hit,
  output wire io_rsvd,
  output wire ram_win
);
  always @* begin
    casez (addr[31:29])
      3'b0??: region = `ASD_RG_LOW;
      3'b100: region = `ASD_RG_CDIR;
      3'b101: region = `ASD_RG_UDIR;
      3'b110: region = `ASD_RG_MHIGH;
      default: region = `ASD_RG_IO;
    endcase
  end
  assign stq_hit = (addr[31:26] == `ASD_STQ_TOP);
  assign arr_hit = (addr[31:27] == `ASD_ARR_TOP);
  assign arr_sel = addr[26:24];
  assign ctl_hit = (addr[31:26] == `ASD_CTL_TOP);
  assign io_rsvd = (region == `ASD_RG_IO) & ~stq_hit & ~arr_hit & ~ctl_hit;
  assign ram_win = (addr[31:26] == `ASD_RAM_TOP);
endmodule

// file: hdl/asd_regs.vh
// constants of the address space decoder
// Contract
// - translation off: the 32-bit address is used directly as physical
// - external address is the physical address minus its top three bits
// - privileged mode reaches all 4 Gbytes, user mode only the low 2 Gbytes
// - user access above the low region faults, store queue range excepted
// - untranslated caching follows cache settings; cached-direct uses copy-back bit
// - uncached-direct region never cached; maps to address with top bits zero
// - E000_0000 to E3FF_FFFF decodes as store queue access
// - F000_0000 to F7FF_FFFF decodes as eight 16-Mbyte array windows
// - FC00_0000 upward is control registers, F800_0000 reserved; on-chip I/O uncached
// - translation off: store queue permission from store queue mode bit
// - external space is eight areas; area 7 reserved also in direct regions
// - translation on: low, mapped-high and user regions go through the TLB
// - translation is qualified by an 8-bit address space identifier
// - translated access to 1C00_0000..1FFF_FFFF reaches control registers
// - translation on: 7C00_0000..7FFF_FFFF is not translated
// - translated caching needs cache enable and page cacheable; page sets write-through
// - card pages use write-through or uncached; page attribute and timing fields apply
// - card areas are refused through direct and on-chip I/O regions
// - untranslated card access uses the page assistance register fields
// - DMA card accesses use the DMA channel fields, ignoring page settings
// - direct and I/O regions pass untranslated; only store queue may be remapped
// - RAM mode: 7C00_0000..7FFF_FFFF is on-chip RAM for data accesses of any size
// - translation off: no translation-unit exceptions
// - user store queue access faults while store queue mode bit is 1; the code faults only with translation off
`ifndef ASD_REGS_VH
`define ASD_REGS_VH
// register byte offsets
`define ASD_OFF_CTRL 8'h00
`define ASD_OFF_CACHE 8'h04
`define ASD_OFF_SPACE_ID 8'h08
`define ASD_OFF_ASSIST 8'h0c
`define ASD_OFF_STATUS 8'h10
`define ASD_OFF_ERRCNT 8'h14
// field positions
`define ASD_CTRL_XLATE 0
`define ASD_CTRL_STQ_MODE 1
`define ASD_CACHE_CE 0
`define ASD_CACHE_GLOBAL_WTHRU 1
`define ASD_CACHE_CPBACK 2
`define ASD_CACHE_RAM_MODE 3
`define ASD_ASSIST_ATTR_MSB 2
`define ASD_ASSIST_TSEL 3
// reset values
`define ASD_RST_CTRL 2'h0
`define ASD_RST_CACHE 4'h0
`define ASD_RST_SPACE_ID 8'h00
`define ASD_RST_ASSIST 4'h0
// region codes
`define ASD_RG_LOW 3'h0
`define ASD_RG_CDIR 3'h1
`define ASD_RG_UDIR 3'h2
`define ASD_RG_MHIGH 3'h3
`define ASD_RG_IO 3'h4
// address windows, upper bits
`define ASD_STQ_TOP 6'h38
`define ASD_ARR_TOP 5'h1e
`define ASD_CTL_TOP 6'h3f
`define ASD_RAM_TOP 6'h1f
`define ASD_CIMG_TOP 3'h7
// card interface areas
`define ASD_AREA_CARD_LO 3'h5
`define ASD_AREA_CARD_HI 3'h6
`endif

// file: hdl/asd_top.v
// address space decoder with ahb-lite register slave
//
// The register offsets and the AHB-Lite slave port were decided locally.
`timescale 1ns/10ps
`include "asd_regs.vh"
module asd_top #(
  parameter UNTRANS_CARD = 1
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // access request
  input wire acc_valid,
  input wire [31:0] acc_addr,
  input wire acc_user,
  input wire acc_write,
  input wire acc_ifetch,
  input wire [1:0] acc_size,
  input wire acc_dma,
  // dma channel fields
  input wire [2:0] dma_channel_space_attribute,
  input wire dma_channel_timing_select,
  // tlb lookup result
  input wire tlb_hit,
  input wire [28:0] tlb_paddr,
  input wire page_cacheable,
  input wire page_write_through_bit,
  input wire [2:0] page_space_attribute,
  input wire page_timing_select,
  // translation context
  output wire translation_enable_bit,
  output wire [7:0] address_space_identifier,
  output wire tlb_lookup,
  // decoded access
  output reg res_valid,
  output reg [28:0] res_ext_addr,
  output reg [2:0] res_region,
  output reg [2:0] res_area,
  output reg res_translated,
  output reg res_cacheable,
  output reg res_write_through,
  output reg res_store_queue,
  output reg res_array,
  output reg [2:0] res_array_sel,
  output reg res_ctrl_reg,
  output reg res_reserved,
  output reg res_onchip_ram,
  output reg res_external,
  output reg res_card,
  output reg [2:0] res_space_attribute,
  output reg res_timing_select,
  output reg res_addr_error,
  output reg res_tlb_miss
);
  // register state
  reg [1:0] ctrl_q;
  reg [3:0] cache_q;
  reg [7:0] space_id_q;
  reg [3:0] assist_q;
  reg [15:0] errcnt_q;
  // ahb data-phase state
  reg wr_pend_q;
  reg [7:0] wr_addr_q;
  wire addr_ph;
  wire [7:0] hoff;
  reg [31:0] rd_d;

  wire store_queue_mode_bit;
  wire cache_en;
  wire global_write_through_bit;
  wire copy_back_select_bit;
  wire operand_cache_ram_mode_bit;

  // control and cache setting fields
  assign store_queue_mode_bit = ctrl_q[`ASD_CTRL_STQ_MODE];
  assign cache_en = cache_q[`ASD_CACHE_CE];
  assign global_write_through_bit = cache_q[`ASD_CACHE_GLOBAL_WTHRU];
  assign copy_back_select_bit = cache_q[`ASD_CACHE_CPBACK];
  assign operand_cache_ram_mode_bit = cache_q[`ASD_CACHE_RAM_MODE];

  assign translation_enable_bit = ctrl_q[`ASD_CTRL_XLATE];
  assign address_space_identifier = space_id_q;

  // zero-wait slave, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_ph = hsel & htrans[1] & hready;
  assign hoff = haddr[7:0];

  // read data is prepared in the address phase
  always @* begin
    rd_d = 32'h0000_0000;
    case (hoff)
      `ASD_OFF_CTRL: rd_d[1:0] = ctrl_q;
      `ASD_OFF_CACHE: rd_d[3:0] = cache_q;
      `ASD_OFF_SPACE_ID: rd_d[7:0] = space_id_q;
      `ASD_OFF_ASSIST: rd_d[3:0] = assist_q;
      `ASD_OFF_STATUS: rd_d[15:0] = {res_addr_error, res_tlb_miss,
                                      res_card, res_external,
                                      res_onchip_ram, res_reserved,
                                      res_ctrl_reg, res_array,
                                      res_store_queue, res_write_through,
                                      res_cacheable, res_translated,
                                      res_valid, res_region};
      `ASD_OFF_ERRCNT: rd_d[15:0] = errcnt_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      if (hready) begin
        wr_pend_q <= addr_ph & hwrite;
        wr_addr_q <= hoff;
      end
      if (addr_ph & ~hwrite) begin
        hrdata <= rd_d;
      end
    end
  end

  // register writes in the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `ASD_RST_CTRL;
      cache_q <= `ASD_RST_CACHE;
      space_id_q <= `ASD_RST_SPACE_ID;
      assist_q <= `ASD_RST_ASSIST;
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        `ASD_OFF_CTRL: ctrl_q <= hwdata[1:0];
        `ASD_OFF_CACHE: cache_q <= hwdata[3:0];
        `ASD_OFF_SPACE_ID: space_id_q <= hwdata[7:0];
        `ASD_OFF_ASSIST: assist_q <= hwdata[3:0];
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // address classification
  wire [2:0] region;
  wire stq_hit;
  wire arr_hit;
  wire [2:0] arr_sel;
  wire ctl_hit;
  wire io_rsvd;
  wire ram_win;

  asd_region u_region (
    .addr(acc_addr),
    .region(region),
    .stq_hit(stq_hit),
    .arr_hit(arr_hit),
    .arr_sel(arr_sel),
    .ctl_hit(ctl_hit),
    .io_rsvd(io_rsvd),
    .ram_win(ram_win)
  );

  wire is_low;
  wire is_mhigh;
  wire is_cdir;
  wire is_udir;
  wire is_io;
  wire ram_hit;
  wire xl_excl;
  wire use_tlb;

  assign is_low = (region == `ASD_RG_LOW);
  assign is_mhigh = (region == `ASD_RG_MHIGH);
  assign is_cdir = (region == `ASD_RG_CDIR);
  assign is_udir = (region == `ASD_RG_UDIR);
  assign is_io = (region == `ASD_RG_IO);
  assign ram_hit = is_low & ram_win & operand_cache_ram_mode_bit;
  // the top 64 Mbytes of the low region bypass the tlb
  assign xl_excl = is_low & ram_win;
  // direct and io regions never translate, store queue may
  assign use_tlb = translation_enable_bit &
                   (((is_low | is_mhigh) & ~xl_excl) | stq_hit);
  assign tlb_lookup = acc_valid & use_tlb;

  // bus address: physical minus top bits, or the tlb result
  wire [28:0] ext_d;
  assign ext_d = use_tlb ? tlb_paddr : acc_addr[28:0];

  wire [2:0] area;
  wire card;
  wire area7;
  wire ctl_img;

  asd_area u_area (
    .ext_addr(ext_d),
    .area(area),
    .card(card),
    .area7(area7),
    .ctl_img(ctl_img)
  );

  // translated area 7 image of the control registers
  wire tl_ctl;
  wire ext_path;
  wire rsvd_d;

  assign tl_ctl = use_tlb & ~stq_hit & area7 & ctl_img;
  assign ext_path = (is_low | is_mhigh | is_cdir | is_udir) & ~ram_hit;
  assign rsvd_d = (ext_path & area7 & ~tl_ctl) | io_rsvd;

  // privilege checks
  wire user_hi;
  wire stq_deny;
  wire card_deny;
  wire ram_deny;
  wire err_d;

  assign user_hi = acc_user & ~is_low & ~stq_hit;
  // store queue mode bit guards only untranslated store queue access
  assign stq_deny = acc_user & stq_hit & ~translation_enable_bit &
                    store_queue_mode_bit;
  assign card_deny = ~acc_dma & card & ext_path &
                     ((is_cdir | is_udir) |
                      (~use_tlb & (UNTRANS_CARD == 0)));
  assign ram_deny = ram_hit & acc_ifetch;
  assign err_d = user_hi | stq_deny | card_deny | ram_deny;

  // tlb miss only ever raised with translation on
  wire miss_d;
  assign miss_d = use_tlb & ~tlb_hit & ~err_d;

  // caching and write policy
  reg cach_d;
  reg wthru_d;
  always @* begin
    cach_d = 1'b0;
    wthru_d = 1'b0;
    if (use_tlb) begin
      cach_d = cache_en & page_cacheable & ~stq_hit & ~tl_ctl;
      wthru_d = page_write_through_bit;
    end else if ((is_low | is_mhigh | is_cdir) & ~ram_hit) begin
      cach_d = cache_en;
      // cached-direct writes through unless copy-back is selected
      wthru_d = is_cdir ? ~copy_back_select_bit : global_write_through_bit;
    end
    if (rsvd_d | is_udir | is_io) begin
      cach_d = 1'b0;
    end
  end

  // card space attribute and timing select source
  wire [2:0] assist_attr;
  wire assist_tsel;
  assign assist_attr = assist_q[`ASD_ASSIST_ATTR_MSB:0];
  assign assist_tsel = assist_q[`ASD_ASSIST_TSEL];
  reg [2:0] attr_d;
  reg tsel_d;
  always @* begin
    attr_d = 3'h0;
    tsel_d = 1'b0;
    if (card & ext_path) begin
      if (acc_dma) begin
        attr_d = dma_channel_space_attribute;
        tsel_d = dma_channel_timing_select;
      end else if (use_tlb) begin
        attr_d = page_space_attribute;
        tsel_d = page_timing_select;
      end else begin
        attr_d = assist_attr;
        tsel_d = assist_tsel;
      end
    end
  end

  // one-cycle registered result
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_valid <= 1'b0;
      res_ext_addr <= 29'h0000_0000;
      res_region <= 3'h0;
      res_area <= 3'h0;
      res_translated <= 1'b0;
      res_cacheable <= 1'b0;
      res_write_through <= 1'b0;
      res_store_queue <= 1'b0;
      res_array <= 1'b0;
      res_array_sel <= 3'h0;
      res_ctrl_reg <= 1'b0;
      res_reserved <= 1'b0;
      res_onchip_ram <= 1'b0;
      res_external <= 1'b0;
      res_card <= 1'b0;
      res_space_attribute <= 3'h0;
      res_timing_select <= 1'b0;
      res_addr_error <= 1'b0;
      res_tlb_miss <= 1'b0;
    end else begin
      res_valid <= acc_valid;
      if (acc_valid) begin
        res_ext_addr <= ext_d;
        res_region <= region;
        res_area <= area;
        res_translated <= use_tlb;
        res_cacheable <= cach_d & ~err_d;
        res_write_through <= wthru_d;
        res_store_queue <= stq_hit;
        res_array <= arr_hit;
        res_array_sel <= arr_sel;
        res_ctrl_reg <= ctl_hit | tl_ctl;
        res_reserved <= rsvd_d;
        res_onchip_ram <= ram_hit;
        res_external <= ext_path & ~rsvd_d & ~tl_ctl & ~err_d;
        res_card <= card & ext_path;
        res_space_attribute <= attr_d;
        res_timing_select <= tsel_d;
        res_addr_error <= err_d;
        res_tlb_miss <= miss_d;
      end
    end
  end

  // count of address errors, saturating
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      errcnt_q <= 16'h0000;
    end else if (acc_valid & err_d & (errcnt_q != 16'hffff)) begin
      errcnt_q <= errcnt_q + 16'h0001;
    end
  end

  // acc_write and acc_size are accepted for every size at the ram window
  wire unused_ok;
  assign unused_ok = acc_write | (|acc_size) | (|hsize) | (|haddr[31:8]);

endmodule

// file: tb/asd_chk_sva.sv
// port assertions for the address space decoder
`timescale 1ns/10ps
module asd_chk (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // access request
  input wire acc_valid,
  input wire [31:0] acc_addr,
  input wire acc_user,
  // context and result
  input wire translation_enable_bit,
  input wire tlb_lookup,
  input wire res_valid,
  input wire [28:0] res_ext_addr,
  input wire [2:0] res_region,
  input wire [2:0] res_area,
  input wire res_translated,
  input wire res_cacheable,
  input wire res_store_queue,
  input wire res_array,
  input wire [2:0] res_array_sel,
  input wire res_addr_error,
  input wire res_tlb_miss
);
  default clocking clk_ev @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_take;
    acc_valid;
  endsequence
  sequence s_priv_take;
    acc_valid && !acc_user;
  endsequence
  a_result_next: assert property (res_valid == $past(acc_valid))
    else $error("result strobe not one cycle after request");
  a_direct_strip: assert property (s_priv_take ##0 (!translation_enable_bit &&
    acc_addr[31:29] == 3'b101 && acc_addr[28:26] < 3'h5) |=>
    res_ext_addr == $past(acc_addr[28:0]) && !res_cacheable)
    else $error("uncached direct access decoded wrongly");
  a_user_fault: assert property (s_take ##0 (acc_user && acc_addr[31] &&
    acc_addr[31:26] != 6'h38) |=> res_addr_error)
    else $error("user access above low region not faulted");
  a_user_low_ok: assert property (s_take ##0 (acc_user && !acc_addr[31] &&
    !translation_enable_bit && acc_addr[28:26] < 3'h5) |=> !res_addr_error)
    else $error("user low access faulted");
  a_sq_decode: assert property (s_take ##0 (acc_addr[31:26] == 6'h38) |=> res_store_queue)
    else $error("store queue range not decoded");
  a_array_window: assert property (s_priv_take ##0 (acc_addr[31:27] == 5'h1e) |=>
    res_array && res_array_sel == $past(acc_addr[26:24]))
    else $error("array window wrong");
  a_io_uncached: assert property (res_valid && res_region == 3'h4 |-> !res_cacheable)
    else $error("on-chip io access cached");
  a_area_field: assert property (res_valid |-> res_area == res_ext_addr[28:26])
    else $error("area does not follow bus address");
  a_no_xlate_off: assert property (s_take ##0 !translation_enable_bit |->
    !tlb_lookup ##1 (!res_tlb_miss && !res_translated))
    else $error("translation activity while disabled");
  a_region_code: assert property (s_priv_take |=> res_region ==
    ($past(acc_addr[31]) ? {1'b0, $past(acc_addr[30:29])} + 3'h1 : 3'h0))
    else $error("region code wrong");
  a_direct_plain: assert property (s_take ##0 (acc_addr[31:29] == 3'b100) |-> !tlb_lookup)
    else $error("cached direct access looked up");
endmodule

bind asd_top asd_chk i_chk (.hclk(hclk), .hresetn(hresetn), .acc_valid(acc_valid),
  .acc_addr(acc_addr), .acc_user(acc_user), .translation_enable_bit(translation_enable_bit),
  .tlb_lookup(tlb_lookup), .res_valid(res_valid), .res_ext_addr(res_ext_addr),
  .res_region(res_region), .res_area(res_area), .res_translated(res_translated),
  .res_cacheable(res_cacheable), .res_store_queue(res_store_queue), .res_array(res_array),
  .res_array_sel(res_array_sel), .res_addr_error(res_addr_error), .res_tlb_miss(res_tlb_miss));

// file: tb/asd_tlb_model.sv
// one-page tlb responder standing for the cpu side
`timescale 1ns/10ps
module asd_tlb_model (
  // lookup
  input wire acc_valid,
  input wire [31:0] acc_addr,
  // page as set by software
  input wire pg_valid,
  input wire [8:0] pg_ppn,
  input wire pg_c,
  input wire pg_wthru,
  input wire [2:0] pg_attr,
  input wire pg_tsel,
  // result
  output wire tlb_hit,
  output wire [28:0] tlb_paddr,
  output wire page_cacheable,
  output wire page_write_through_bit,
  output wire [2:0] page_space_attribute,
  output wire page_timing_select
);
  wire [28:0] pa = {pg_ppn, acc_addr[19:0]};
  wire ctl_page = pg_ppn[8:6] == 3'h7;
  wire card_page = pg_ppn[8:6] == 3'h5 || pg_ppn[8:6] == 3'h6;
  // idle tlb_paddr shows an inverted pattern, not the last value; tlb_hit goes low
  assign tlb_hit = acc_valid & pg_valid;
  assign tlb_paddr = acc_valid ? pa : ~pa;
  assign page_cacheable = pg_c & ~ctl_page;
  assign page_write_through_bit = pg_wthru | card_page;
  assign page_space_attribute = pg_attr;
  assign page_timing_select = pg_tsel;
endmodule

// file: tb/tb_top.sv
// self-checking bench for the address space decoder
`timescale 1ns/10ps
`include "asd_regs.vh"
module tb_top;
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg hsel = 1'b0, hwrite = 1'b0, acc_valid = 1'b0, acc_user = 1'b0, acc_dma = 1'b0;
  reg [1:0] htrans = 2'h0;
  reg [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, acc_addr = 32'h0000_0000;
  reg [2:0] dsa = 3'h0, pg_attr = 3'h0;
  reg dtc = 1'b0, pg_valid = 1'b0, pg_c = 1'b0, pg_wthru = 1'b0, pg_tsel = 1'b0;
  reg acc_ifetch = 1'b0;
  reg [8:0] pg_ppn = 9'h000;
  wire hready, hresp, tlb_hit, pc, pw, pt, teb, res_valid, res_translated, res_cacheable;
  wire res_write_through, res_store_queue, res_array, res_ctrl_reg, res_reserved;
  wire res_onchip_ram, res_card, res_timing_select, res_addr_error, res_tlb_miss, res_external;
  wire [31:0] hrdata;
  wire [28:0] tlb_paddr, res_ext_addr;
  wire [2:0] ps, res_array_sel, res_space_attribute;
  wire [7:0] space_id;
  int failures = 0;
  int tests_run = 0;
  always #12.5 hclk = ~hclk;
  asd_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .acc_valid(acc_valid), .acc_addr(acc_addr),
    .acc_user(acc_user), .acc_write(1'b0), .acc_ifetch(acc_ifetch), .acc_size(2'h2),
    .acc_dma(acc_dma), .dma_channel_space_attribute(dsa), .dma_channel_timing_select(dtc),
    .tlb_hit(tlb_hit), .tlb_paddr(tlb_paddr), .page_cacheable(pc),
    .page_write_through_bit(pw), .page_space_attribute(ps), .page_timing_select(pt),
    .translation_enable_bit(teb), .address_space_identifier(space_id), .tlb_lookup(),
    .res_valid(res_valid), .res_ext_addr(res_ext_addr), .res_region(), .res_area(),
    .res_translated(res_translated), .res_cacheable(res_cacheable),
    .res_write_through(res_write_through), .res_store_queue(res_store_queue),
    .res_array(res_array), .res_array_sel(res_array_sel), .res_ctrl_reg(res_ctrl_reg),
    .res_reserved(res_reserved), .res_onchip_ram(res_onchip_ram), .res_external(res_external),
    .res_card(res_card), .res_space_attribute(res_space_attribute),
    .res_timing_select(res_timing_select), .res_addr_error(res_addr_error),
    .res_tlb_miss(res_tlb_miss));
  asd_tlb_model i_tlb (.acc_valid(acc_valid), .acc_addr(acc_addr), .pg_valid(pg_valid),
    .pg_ppn(pg_ppn), .pg_c(pg_c), .pg_wthru(pg_wthru), .pg_attr(pg_attr), .pg_tsel(pg_tsel),
    .tlb_hit(tlb_hit), .tlb_paddr(tlb_paddr), .page_cacheable(pc),
    .page_write_through_bit(pw), .page_space_attribute(ps), .page_timing_select(pt));
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 16);
    if (n >= 16) begin
      failures++;
      tally_and_finish;
    end
  endtask
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    hsel <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk("hrdata", e, hrdata);
    chk("hresp", 0, hresp);
  endtask
  task automatic acc(input logic [31:0] a, input logic u, input logic d);
    int n;
    @(posedge hclk);
    acc_valid <= 1'b1;
    acc_addr <= a;
    acc_user <= u;
    acc_dma <= d;
    @(posedge hclk);
    acc_valid <= 1'b0;
    #1;
    n = 0;
    while (res_valid !== 1'b1 && n < 8) begin
      @(posedge hclk);
      #1;
      n++;
    end
    if (n >= 8) begin
      failures++;
      tally_and_finish;
    end
  endtask
  task automatic t_regs;
    chk("enable", 0, teb);
    chk("res_valid", 0, res_valid);
    rd_chk(`ASD_OFF_CACHE, 0);
    rd_chk(`ASD_OFF_ASSIST, 0);
    bus(1'b1, `ASD_OFF_SPACE_ID, 32'h0000_01a5);
    rd_chk(`ASD_OFF_SPACE_ID, 32'h0000_00a5);
    chk("space_id", 8'ha5, space_id);
    bus(1'b1, 8'h20, 32'hffff_ffff);
    rd_chk(8'h20, 0);
  endtask
  task automatic t_phys;
    bus(1'b1, `ASD_OFF_CACHE, 32'h0000_0007);
    acc(32'h0c00_0100, 1'b0, 1'b0);
    chk("ext", 29'h0c00_0100, res_ext_addr);
    chk("wthru", 1, res_cacheable & res_write_through);
    chk("external", 1, res_external);
    acc(32'h8000_0040, 1'b0, 1'b0);
    chk("cpback", 1, res_cacheable & ~res_write_through);
    acc(32'ha400_0000, 1'b0, 1'b0);
    chk("uncached", 0, res_cacheable);
    chk("ext", 29'h0400_0000, res_ext_addr);
    acc(32'hbc00_0000, 1'b0, 1'b0);
    chk("rsvd", 1, res_reserved);
    chk("external", 0, res_external);
  endtask
  task automatic t_onchip;
    acc(32'he000_0000, 1'b0, 1'b0);
    chk("stq", 1, res_store_queue);
    for (int i = 0; i < 8; i++) begin
      acc(32'hf000_0000 + (i << 24), 1'b0, 1'b0);
      chk("sel", i + 8, {res_array, res_array_sel});
    end
    acc(32'hfc00_0010, 1'b0, 1'b0);
    chk("ctl", 1, res_ctrl_reg & ~res_cacheable);
    acc(32'hf800_0000, 1'b0, 1'b0);
    chk("rsvd", 1, res_reserved);
  endtask
  task automatic t_user;
    acc(32'h4000_0000, 1'b1, 1'b0);
    chk("err", 0, res_addr_error);
    acc(32'ha000_0000, 1'b1, 1'b0);
    chk("err", 1, res_addr_error);
    acc(32'he000_0000, 1'b1, 1'b0);
    chk("err", 0, res_addr_error);
    bus(1'b1, `ASD_OFF_CTRL, 32'h0000_0002);
    acc(32'he000_0000, 1'b1, 1'b0);
    chk("err", 1, res_addr_error);
    bus(1'b1, `ASD_OFF_CTRL, 32'h0000_0000);
  endtask
  task automatic t_card;
    bus(1'b1, `ASD_OFF_ASSIST, 32'h0000_000d);
    acc(32'h1400_0000, 1'b0, 1'b0);
    chk("card", 4'hd, {res_card, res_space_attribute});
    chk("tsel", 1, res_timing_select);
    @(posedge hclk);
    dsa <= 3'h2;
    acc(32'h1800_0000, 1'b0, 1'b1);
    chk("dma", 4'ha, {res_card, res_space_attribute});
    chk("tsel", 0, res_timing_select);
    acc(32'hb400_0000, 1'b0, 1'b0);
    chk("err", 1, res_addr_error);
  endtask
  task automatic t_trans;
    @(posedge hclk);
    pg_ppn <= 9'h004;
    pg_c <= 1'b1;
    pg_valid <= 1'b1;
    bus(1'b1, `ASD_OFF_CACHE, 32'h0000_0001);
    bus(1'b1, `ASD_OFF_CTRL, 32'h0000_0001);
    acc(32'hc012_3450, 1'b0, 1'b0);
    chk("ext", 29'h0042_3450, res_ext_addr);
    chk("xl", 3, {res_translated, res_cacheable});
    @(posedge hclk);
    pg_ppn <= 9'h1c0;
    acc(32'h0000_0010, 1'b1, 1'b0);
    chk("ctl", 2, {res_ctrl_reg, res_addr_error});
    @(posedge hclk);
    pg_ppn <= 9'h140;
    pg_attr <= 3'h3;
    acc(32'h0000_0010, 1'b0, 1'b0);
    chk("card", 5'h1b, {res_card, res_write_through, res_space_attribute});
    acc(32'h7c00_0000, 1'b0, 1'b0);
    chk("xl", 0, res_translated);
    acc(32'h8400_0020, 1'b0, 1'b0);
    chk("xl", 0, res_translated);
    chk("ext", 29'h0400_0020, res_ext_addr);
    bus(1'b1, `ASD_OFF_CACHE, 32'h0000_0009);
    acc(32'h7c00_0000, 1'b0, 1'b0);
    chk("ram", 1, res_onchip_ram);
    @(posedge hclk);
    acc_ifetch <= 1'b1;
    acc(32'h7c00_0000, 1'b0, 1'b0);
    chk("fetch", 1, res_addr_error);
    @(posedge hclk);
    acc_ifetch <= 1'b0;
    @(posedge hclk);
    pg_valid <= 1'b0;
    acc(32'h0000_1000, 1'b0, 1'b0);
    chk("miss", 1, res_tlb_miss);
    rd_chk(`ASD_OFF_ERRCNT, 32'h0000_0004);
  endtask
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_phys;
    t_onchip;
    t_user;
    t_card;
    t_trans;
    tally_and_finish;
  end
endmodule
